// *** pkg/mic_pkg.sv ***
// ==========================================================
// interrupt controller constants and carriers
package mic_pkg;

  // ==========================================================
  // bus widths and register offsets (byte addresses)
  localparam int MIC_ADDR_W = 8;
  localparam logic [7:0] MIC_OFF_ICR = 8'h00;
  localparam logic [7:0] MIC_OFF_OPT = 8'h04;
  localparam logic [7:0] MIC_OFF_PFA = 8'h08;
  localparam logic [7:0] MIC_OFF_PFB = 8'h0C;
  localparam logic [7:0] MIC_OFF_PEA = 8'h10;
  localparam logic [7:0] MIC_OFF_PEB = 8'h14;
  localparam logic [7:0] MIC_OFF_STAT = 8'h18;

  // ==========================================================
  // interrupt control, option and peripheral flag register bit positions
  localparam int MIC_ICR_GIE = 7;
  localparam int MIC_ICR_PEIE = 6;
  localparam int MIC_ICR_TIMER_ZERO_OVF_ENABLE = 5;
  localparam int MIC_ICR_EXTIE = 4;
  localparam int MIC_ICR_PCIE = 3;
  localparam int MIC_ICR_TIMER_ZERO_OVF_FLAG = 2;
  localparam int MIC_ICR_EXTIF = 1;
  localparam int MIC_ICR_PCIF = 0;
  localparam int MIC_OPT_EDGE = 6;
  localparam int MIC_PFA_PSP = 7;

  // ==========================================================
  // reset values, implemented-bit masks and timer limits
  localparam logic [7:0] MIC_ICR_RST = 8'h00;
  localparam logic [7:0] MIC_OPT_RST = 8'hFF;
  localparam logic [7:0] MIC_PER_RST = 8'h00;
  localparam logic [7:0] MIC_PFB_MASK = 8'h07;
  localparam logic [7:0] MIC_TMR_MAX = 8'hFF;
  localparam logic [7:0] MIC_TMR_MIN = 8'h00;

  // ==========================================================
  // timing, vector and bus response codes
  localparam int MIC_CLK_HZ = 50_000_000;
  localparam int MIC_INSTR_CLKS = 4;
  localparam logic [2:0] MIC_INSTR_LAST = 3'(MIC_INSTR_CLKS - 1);
  localparam int MIC_LAT_MIN_INSTR = 3;
  localparam int MIC_LAT_MAX_INSTR = 4;
  localparam logic [1:0] MIC_LAT_LAST = 2'(MIC_LAT_MIN_INSTR);
  localparam logic [12:0] MIC_VECTOR = 13'h0004;
  localparam logic [1:0] MIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] MIC_RESP_SLVERR = 2'h2;

  // ==========================================================
  // axi4-lite carriers, master to slave and back
  typedef struct packed {
    logic [MIC_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [MIC_ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } mic_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } mic_axi_rsp_t;

endpackage

// *** logic/mic_edge_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// pin synchronisers with edge and change detection
module mic_edge_detect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_hi,
  input wire logic rising_sel,
  output logic ext_edge,
  output logic port_change
);

  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] prev_reg;
  logic [2:0] arm_reg;

  // two-stage synchroniser; stage one is read only by stage two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {port_b_hi, ext_irq_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // last settled value, the reference for edges and changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 5'h00;
    end else begin
      prev_reg <= sync2_reg;
    end
  end

  // edges ignored until the pipeline holds real pin values, so a pin
  // idling high at reset raises no false flag; costs three cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_reg <= 3'h0;
    end else begin
      arm_reg <= {arm_reg[1:0], 1'b1};
    end
  end

  // rising or falling edge picked by the select bit
  assign ext_edge = arm_reg[2] &
    (rising_sel ? (sync2_reg[0] & ~prev_reg[0])
                : (~sync2_reg[0] & prev_reg[0]));
  // any mismatch on the upper nibble counts as a change
  assign port_change = arm_reg[2] & (|(sync2_reg[4:1] ^ prev_reg[4:1]));

endmodule
`default_nettype wire

// *** logic/mic_irq_ctrl.sv ***
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: flags set on their event regardless of individual or global enable
// RULE2: global enable at control bit 7 gates every unmasked interrupt
// RULE3: global enable plus flag and enable pair vectors; enable clear blocks
// RULE4: every reset clears the global enable
// RULE5: return-from-interrupt instruction sets the global enable again
// RULE6: on accept clear global enable, push return address, load 0004h
// RULE7: two peripheral flag and enable pairs, group enable in control reg
// RULE8: pin and port-change latency is three or four instruction cycles
// RULE9: pin is edge triggered, option bit 6 selects rising when set
// RULE10: pin edge sets flag bit 1, enable at bit 4
// RULE11: pin interrupt wakes from sleep if enabled; global enable decides vector
// RULE12: timer zero FFh to 00h sets flag bit 2, enable bit 5
// RULE13: port B bits 7:4 change sets flag bit 0 with own enable
// RULE14: only the return address is pushed, nothing else saved
// RULE15: software clears serviced flags before re-enabling interrupts
// RULE16: up to fourteen sources; small variant drops parallel slave flag
// RULE17: cause found by polling flags, no encoded cause
// RULE18: enabled flagged source wakes from sleep whatever global enable
// RULE19: power-on reset clears upper seven control bits
// RULE20: peripheral pairs gated by group enable then merged with core ones
module mic_irq_ctrl #(
  parameter bit HAS_PSP = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire mic_pkg::mic_axi_req_t axi_req,
  output mic_pkg::mic_axi_rsp_t axi_rsp,
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_pins,
  input wire logic [7:0] timer_zero,
  input wire logic [7:0] periph_set_a,
  input wire logic [7:0] periph_set_b,
  input wire logic [12:0] return_pc,
  input wire logic return_from_irq_instr,
  input wire logic sleep_instr,
  output logic irq_pending,
  output logic vector_load,
  output logic [12:0] vector_addr,
  output logic stack_push,
  output logic [12:0] push_addr,
  output logic asleep,
  output logic wake
);

  // ==========================================================
  // register file
  logic [7:0] interrupt_control_reg;
  logic [7:0] option_reg;
  logic [7:0] periph_flag_reg_a;
  logic [7:0] periph_flag_reg_b;
  logic [7:0] periph_enable_reg_a;
  logic [7:0] periph_enable_reg_b;
  logic [7:0] pfa_mask;

  // ==========================================================
  // bus slave state
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic wr_icr, wr_opt, wr_pfa, wr_pfb, wr_pea, wr_peb;

  // ==========================================================
  // event and request state
  logic ext_edge, port_change, tmr_ovf;
  logic [7:0] tmr_prev_reg;
  logic [2:0] div_cnt_reg;
  logic instr_en;
  logic [1:0] lat_cnt_reg;
  logic periph_req, core_req, any_req, accept;
  logic asleep_reg, wake_reg, vector_load_reg;
  logic [12:0] push_addr_reg;

  // true when the address hits a mapped register
  function automatic logic mic_mapped(input logic [7:0] a);
    case (a)
      mic_pkg::MIC_OFF_ICR, mic_pkg::MIC_OFF_OPT,
      mic_pkg::MIC_OFF_PFA, mic_pkg::MIC_OFF_PFB,
      mic_pkg::MIC_OFF_PEA, mic_pkg::MIC_OFF_PEB,
      mic_pkg::MIC_OFF_STAT: mic_mapped = 1'b1;
      default: mic_mapped = 1'b0;
    endcase
  endfunction

  // the small variant has no parallel slave flag bit
  assign pfa_mask = HAS_PSP ? 8'hFF : 8'h7F; // see RULE16

  // ==========================================================
  // pin front end and timer overflow
  mic_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_irq_pin(ext_irq_pin),
    .port_b_hi(port_b_pins),
    .rising_sel(option_reg[mic_pkg::MIC_OPT_EDGE]), // see RULE9
    .ext_edge(ext_edge),
    .port_change(port_change)
  );

  // previous timer value, same clock domain so no synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_prev_reg <= mic_pkg::MIC_TMR_MIN;
    end else begin
      tmr_prev_reg <= timer_zero;
    end
  end
  assign tmr_ovf = (tmr_prev_reg == mic_pkg::MIC_TMR_MAX) &&
                   (timer_zero == mic_pkg::MIC_TMR_MIN); // see RULE12

  // ==========================================================
  // axi4-lite write path: address and data taken in either order
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (axi_req.awvalid && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= axi_req.awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (axi_req.wvalid && !w_held_reg) begin
      w_held_reg <= 1'b1;
      wdata_reg <= axi_req.wdata[7:0];
      wstrb0_reg <= axi_req.wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // write response; unmapped addresses answer slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= mic_pkg::MIC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= mic_mapped(awaddr_reg) ? mic_pkg::MIC_RESP_OKAY
                                          : mic_pkg::MIC_RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // per-register strobes; only byte lane 0 carries data
  assign wr_icr = do_write && wstrb0_reg && awaddr_reg == mic_pkg::MIC_OFF_ICR;
  assign wr_opt = do_write && wstrb0_reg && awaddr_reg == mic_pkg::MIC_OFF_OPT;
  assign wr_pfa = do_write && wstrb0_reg && awaddr_reg == mic_pkg::MIC_OFF_PFA;
  assign wr_pfb = do_write && wstrb0_reg && awaddr_reg == mic_pkg::MIC_OFF_PFB;
  assign wr_pea = do_write && wstrb0_reg && awaddr_reg == mic_pkg::MIC_OFF_PEA;
  assign wr_peb = do_write && wstrb0_reg && awaddr_reg == mic_pkg::MIC_OFF_PEB;

  // ==========================================================
  // axi4-lite read path, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= mic_pkg::MIC_RESP_OKAY;
    end else if (axi_req.arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= mic_mapped(axi_req.araddr) ? mic_pkg::MIC_RESP_OKAY
                                              : mic_pkg::MIC_RESP_SLVERR;
      case (axi_req.araddr) // flags read raw, software polls them; see RULE17
        mic_pkg::MIC_OFF_ICR: rdata_reg <= {24'h000000, interrupt_control_reg};
        mic_pkg::MIC_OFF_OPT: rdata_reg <= {24'h000000, option_reg};
        mic_pkg::MIC_OFF_PFA: rdata_reg <= {24'h000000, periph_flag_reg_a};
        mic_pkg::MIC_OFF_PFB: rdata_reg <= {24'h000000, periph_flag_reg_b};
        mic_pkg::MIC_OFF_PEA: rdata_reg <= {24'h000000, periph_enable_reg_a};
        mic_pkg::MIC_OFF_PEB: rdata_reg <= {24'h000000, periph_enable_reg_b};
        mic_pkg::MIC_OFF_STAT: rdata_reg <= {29'h00000000, any_req,
                                             irq_pending, asleep_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else if (axi_req.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign axi_rsp.awready = ~aw_held_reg;
  assign axi_rsp.wready = ~w_held_reg;
  assign axi_rsp.bvalid = bvalid_reg;
  assign axi_rsp.bresp = bresp_reg;
  assign axi_rsp.arready = ~rvalid_reg;
  assign axi_rsp.rvalid = rvalid_reg;
  assign axi_rsp.rdata = rdata_reg;
  assign axi_rsp.rresp = rresp_reg;

  // ==========================================================
  // interrupt control register: enables plus core flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_control_reg <= mic_pkg::MIC_ICR_RST; // see RULE4, see RULE19
    end else begin
      if (wr_icr) begin
        interrupt_control_reg[6:0] <= wdata_reg[6:0];
      end
      // hardware sets win over a same-cycle software clear
      if (port_change) begin
        interrupt_control_reg[mic_pkg::MIC_ICR_PCIF] <= 1'b1; // see RULE13
      end
      if (ext_edge) begin
        interrupt_control_reg[mic_pkg::MIC_ICR_EXTIF] <= 1'b1; // see RULE10
      end
      if (tmr_ovf) begin
        interrupt_control_reg[mic_pkg::MIC_ICR_TIMER_ZERO_OVF_FLAG] <= 1'b1; // see RULE1
      end
      // global enable: accept beats return, return beats software
      if (accept) begin
        interrupt_control_reg[mic_pkg::MIC_ICR_GIE] <= 1'b0; // see RULE6
      end else if (return_from_irq_instr) begin
        interrupt_control_reg[mic_pkg::MIC_ICR_GIE] <= 1'b1; // see RULE5
      end else if (wr_icr) begin
        interrupt_control_reg[mic_pkg::MIC_ICR_GIE] <=
          wdata_reg[mic_pkg::MIC_ICR_GIE]; // see RULE2
      end
    end
  end

  // option register; only the edge select bit is used here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_reg <= mic_pkg::MIC_OPT_RST;
    end else if (wr_opt) begin
      option_reg <= wdata_reg;
    end
  end

  // peripheral flags; source pulses override software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_flag_reg_a <= mic_pkg::MIC_PER_RST;
      periph_flag_reg_b <= mic_pkg::MIC_PER_RST;
    end else begin
      periph_flag_reg_a <= ((wr_pfa ? wdata_reg : periph_flag_reg_a) |
                            periph_set_a) & pfa_mask; // see RULE7
      periph_flag_reg_b <= ((wr_pfb ? wdata_reg : periph_flag_reg_b) |
                            periph_set_b) & mic_pkg::MIC_PFB_MASK;
    end
  end

  // peripheral enables, software owned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_enable_reg_a <= mic_pkg::MIC_PER_RST;
      periph_enable_reg_b <= mic_pkg::MIC_PER_RST;
    end else begin
      if (wr_pea) begin
        periph_enable_reg_a <= wdata_reg & pfa_mask;
      end
      if (wr_peb) begin
        periph_enable_reg_b <= wdata_reg & mic_pkg::MIC_PFB_MASK;
      end
    end
  end

  // ==========================================================
  // request merge: peripheral group first, then the core sources
  assign periph_req = interrupt_control_reg[mic_pkg::MIC_ICR_PEIE] &
    (|(periph_flag_reg_a & periph_enable_reg_a) |
     |(periph_flag_reg_b & periph_enable_reg_b)); // see RULE20
  assign core_req =
    (interrupt_control_reg[mic_pkg::MIC_ICR_TIMER_ZERO_OVF_ENABLE] &
     interrupt_control_reg[mic_pkg::MIC_ICR_TIMER_ZERO_OVF_FLAG]) |
    (interrupt_control_reg[mic_pkg::MIC_ICR_EXTIE] &
     interrupt_control_reg[mic_pkg::MIC_ICR_EXTIF]) |
    (interrupt_control_reg[mic_pkg::MIC_ICR_PCIE] &
     interrupt_control_reg[mic_pkg::MIC_ICR_PCIF]); // see RULE3
  assign any_req = core_req | periph_req;
  assign irq_pending = any_req &
    interrupt_control_reg[mic_pkg::MIC_ICR_GIE]; // see RULE2

  // ==========================================================
  // instruction cycle enable, one pulse every four clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg <= 3'h0;
    end else if (div_cnt_reg == mic_pkg::MIC_INSTR_LAST) begin
      div_cnt_reg <= 3'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end
  assign instr_en = (div_cnt_reg == mic_pkg::MIC_INSTR_LAST);

  // request must hold over four instruction boundaries; the
  // phase of the event inside a cycle gives three or four
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_cnt_reg <= 2'h0;
    end else if (!irq_pending || accept) begin
      lat_cnt_reg <= 2'h0;
    end else if (instr_en && lat_cnt_reg != mic_pkg::MIC_LAT_LAST) begin
      lat_cnt_reg <= lat_cnt_reg + 2'h1; // see RULE8
    end
  end
  // a sleeping core cannot branch; it wakes first
  assign accept = irq_pending & instr_en & ~asleep_reg &
                  (lat_cnt_reg == mic_pkg::MIC_LAT_LAST); // see RULE8

  // vector and push, one cycle pulse; only the pc is saved
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_load_reg <= 1'b0;
      push_addr_reg <= 13'h0000;
    end else begin
      vector_load_reg <= accept; // see RULE6
      if (accept) begin
        push_addr_reg <= return_pc; // see RULE14
      end
    end
  end

  // ==========================================================
  // sleep and wake; a pending enabled source turns sleep into a no-op
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asleep_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= 1'b0;
      if (asleep_reg && any_req) begin
        asleep_reg <= 1'b0; // see RULE18, see RULE11
        wake_reg <= 1'b1;
      end else if (sleep_instr && !any_req) begin
        asleep_reg <= 1'b1;
      end
    end
  end

  assign vector_load = vector_load_reg;
  assign stack_push = vector_load_reg;
  assign vector_addr = mic_pkg::MIC_VECTOR;
  assign push_addr = push_addr_reg;
  assign asleep = asleep_reg;
  assign wake = wake_reg;

endmodule
`default_nettype wire

// *** verification/mic_irq_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checks for the interrupt controller
module mic_irq_ctrl_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire mic_pkg::mic_axi_rsp_t axi_rsp,
  input wire logic [12:0] return_pc,
  input wire logic sleep_instr,
  input wire logic irq_pending,
  input wire logic vector_load,
  input wire logic [12:0] vector_addr,
  input wire logic stack_push,
  input wire logic [12:0] push_addr,
  input wire logic asleep,
  input wire logic wake
);
  logic [7:0] run_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // awake cycles a request has waited; saturates so it never wraps
  always_ff @(posedge aclk) begin
    if (!aresetn || !irq_pending || asleep) begin
      run_reg <= 8'h00;
    end else if (run_reg != 8'hFF) begin
      run_reg <= run_reg + 8'h01;
    end
  end
  a_vec_fixed: assert property (vector_addr == 13'h0004)
    else $error("vector address wrong");
  a_push_pair: assert property (stack_push == vector_load)
    else $error("push and vector differ");
  a_push_ret: assert property (vector_load |->
    push_addr == $past(return_pc)) else $error("pushed address wrong");
  a_vec_cause: assert property (vector_load |->
    $past(irq_pending, 2) && $past(irq_pending, 12))
    else $error("vector without held request");
  a_one_vec: assert property (vector_load |=> !vector_load [*8])
    else $error("second vector too soon");
  a_wait_cap: assert property (run_reg <= 8'h14)
    else $error("request waited too long");
  a_wake_end: assert property (wake |-> !asleep && $past(asleep))
    else $error("wake without leaving sleep");
  a_wake_once: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  a_sleep_cmd: assert property ($rose(asleep) |-> $past(sleep_instr))
    else $error("sleep without instruction");
  a_no_vec_sleep: assert property (asleep |-> !vector_load)
    else $error("vector while asleep");
  a_rd_upper: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
    else $error("read upper bits set");
  c_vec: cover property (vector_load);
  c_wake: cover property (wake);
  c_sleep: cover property ($rose(asleep));
  c_err: cover property (axi_rsp.bvalid && axi_rsp.bresp == 2'h2);
endmodule
bind mic_irq_ctrl mic_irq_ctrl_properties u_props (.aclk, .aresetn,
  .axi_rsp, .return_pc, .sleep_instr, .irq_pending, .vector_load,
  .vector_addr, .stack_push, .push_addr, .asleep, .wake);
`default_nettype wire

// *** verification/mic_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// core sequencer and timer source beside the controller
module mic_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic vector_load,
  input wire logic [12:0] vector_addr,
  input wire logic ret_req,
  input wire logic tmr_run,
  output logic [12:0] return_pc,
  output logic return_from_irq_instr,
  output logic [7:0] timer_zero,
  output logic [12:0] exp_push,
  output logic [7:0] vec_cnt
);
  // pc steps every clock except on a vector load, so a stale push address shows up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      return_pc <= 13'h0100;
    end else if (vector_load) begin
      return_pc <= vector_addr;
    end else begin
      return_pc <= return_pc + 13'h0001;
    end
  end
  // pc as it stood at the accept edge; only pc is kept
  always_ff @(posedge aclk) begin
    exp_push <= return_pc;
  end
  // free counter that wraps from FF to 00 while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_zero <= 8'h00;
    end else begin
      timer_zero <= timer_zero + {7'h00, tmr_run};
    end
  end
  // return instruction one cycle after the bench asks; vector count
  always_ff @(posedge aclk) begin
    return_from_irq_instr <= aresetn && ret_req;
    vec_cnt <= !aresetn ? 8'h00 : vec_cnt + {7'h00, vector_load};
  end
endmodule
`default_nettype wire

// *** verification/mic_irq_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// register-level bench for the interrupt controller
module mic_irq_ctrl_tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  mic_pkg::mic_axi_req_t req = '0;
  mic_pkg::mic_axi_rsp_t rsp;
  logic pin = 1'h0, sleep_instr = 1'h0, ret_req = 1'h0, tmr_run = 1'h0;
  logic [3:0] port_b = 4'h0;
  logic [7:0] set_a = 8'h00, set_b = 8'h00, tmr, vec_cnt, vc;
  logic [12:0] ret_pc, vec_addr, push_addr, exp_push;
  logic ret_i, pend, vec, push, asleep, wake;
  logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [7:0] rstv [6] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  int n_mismatch = 0, n_tests = 0, n;
  always #10 aclk = ~aclk;
  mic_irq_ctrl dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .ext_irq_pin(pin), .port_b_pins(port_b),
    .timer_zero(tmr), .periph_set_a(set_a), .periph_set_b(set_b),
    .return_pc(ret_pc), .return_from_irq_instr(ret_i),
    .sleep_instr(sleep_instr), .irq_pending(pend), .vector_load(vec),
    .vector_addr(vec_addr), .stack_push(push), .push_addr(push_addr),
    .asleep(asleep), .wake(wake));
  mic_core_model u_core (.aclk(aclk), .aresetn(aresetn), .vector_load(vec),
    .vector_addr(vec_addr), .ret_req(ret_req), .tmr_run(tmr_run),
    .return_pc(ret_pc), .return_from_irq_instr(ret_i), .timer_zero(tmr),
    .exp_push(exp_push), .vec_cnt(vec_cnt));
  // ==========================================================
  // verdict, comparison and waiting helpers
  task conclude;
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task give_up;
    chk("wait limit", 32'h0, 32'h1);
    conclude();
  endtask
  // waits for vector (sel 0) or wake (sel 1), bounded
  task wv(input int sel, input int lim);
    for (n = 1; n <= lim; n++) begin
      @(posedge aclk);
      if ((sel == 0 ? vec : wake) === 1'h1) break;
    end
    if (n > lim) give_up();
  endtask
  task no_vec;
    vc = vec_cnt;
    tick(40);
    chk("vec_cnt", vec_cnt, vc);
  endtask
  // ==========================================================
  // axi4-lite master: valids held until their ready edge
  task axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    req.awaddr <= a;
    req.awvalid <= 1'h1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hF;
    req.wvalid <= 1'h1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      if (rsp.bvalid) break;
    end
    if (i == 64) give_up();
    chk("bresp", rsp.bresp, er);
  endtask
  task axr(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    int i;
    req.araddr <= a;
    req.arvalid <= 1'h1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'h0;
      if (rsp.rvalid) break;
    end
    if (i == 64) give_up();
    chk($sformatf("rdata %h", a), rsp.rdata, {24'h0, e});
    chk("rresp", rsp.rresp, er);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    req.bready <= 1'h1;
    req.rready <= 1'h1;
    tick(12);
    aresetn <= 1'h1;
    tick(1);
    for (int j = 0; j < 6; j++) axr(offs[j], rstv[j], 2'h0);
    axr(8'h1C, 8'h00, 2'h2);
    axw(8'h1C, 8'hFF, 2'h2);
    // every event with all enables clear
    set_a <= 8'hFF;
    set_b <= 8'hFF;
    pin <= 1'h1;
    port_b <= 4'h5;
    tmr_run <= 1'h1;
    tick(1);
    set_a <= 8'h00;
    set_b <= 8'h00;
    tick(259);
    tmr_run <= 1'h0;
    axr(8'h00, 8'h07, 2'h0);
    axr(8'h08, 8'hFF, 2'h0);
    axr(8'h0C, 8'h07, 2'h0);
    chk("irq_pending", pend, 1'h0);
    // falling edge selected, rising ignored
    axw(8'h00, 8'h00, 2'h0);
    axw(8'h08, 8'h00, 2'h0);
    axw(8'h04, 8'hBF, 2'h0);
    pin <= 1'h0;
    tick(8);
    axr(8'h00, 8'h02, 2'h0);
    axw(8'h00, 8'h00, 2'h0);
    pin <= 1'h1;
    tick(8);
    axr(8'h00, 8'h00, 2'h0);
    // pin interrupt with the global enable set
    axw(8'h00, 8'h90, 2'h0);
    pin <= 1'h0;
    wv(0, 40);
    chk("latency", n >= 12 && n <= 24, 1'h1);
    chk("push_addr", push_addr, exp_push);
    chk("vector_addr", vec_addr, 13'h0004);
    axr(8'h00, 8'h12, 2'h0);
    // flag cleared before return, so nothing retriggers
    axw(8'h00, 8'h10, 2'h0);
    ret_req <= 1'h1;
    tick(1);
    ret_req <= 1'h0;
    tick(2);
    axr(8'h00, 8'h90, 2'h0);
    no_vec();
    // peripheral sources through the group enable
    axw(8'h10, 8'h01, 2'h0);
    axw(8'h00, 8'hC0, 2'h0);
    set_a <= 8'h01;
    tick(1);
    set_a <= 8'h00;
    wv(0, 40);
    axw(8'h00, 8'h80, 2'h0);
    no_vec();
    axw(8'h10, 8'h00, 2'h0);
    axw(8'h00, 8'hC0, 2'h0);
    no_vec();
    axw(8'h14, 8'h04, 2'h0);
    set_b <= 8'h04;
    tick(1);
    set_b <= 8'h00;
    wv(0, 40);
    // sleep with the global enable clear, then set
    axw(8'h14, 8'h00, 2'h0);
    for (int k = 0; k < 2; k++) begin
      axw(8'h00, k ? 8'h90 : 8'h10, 2'h0);
      sleep_instr <= 1'h1;
      tick(1);
      sleep_instr <= 1'h0;
      tick(2);
      chk("asleep", asleep, 1'h1);
      axr(8'h18, 8'h01, 2'h0);
      pin <= 1'h1;
      tick(4);
      pin <= 1'h0;
      wv(1, 20);
      chk("awake", asleep, 1'h0);
      if (k) wv(0, 40);
      else no_vec();
    end
    // reset in mid-run clears the global enable set just before it
    axw(8'h00, 8'h80, 2'h0);
    axr(8'h00, 8'h80, 2'h0);
    aresetn <= 1'h0;
    tick(2);
    aresetn <= 1'h1;
    tick(1);
    axr(8'h00, 8'h00, 2'h0);
    // port b idles nonzero: no false change flag once pipeline fills
    tick(8);
    axr(8'h00, 8'h00, 2'h0);
    conclude();
  end
endmodule
`default_nettype wire
